// *** hw/eic_pkg.sv ***
// Functional notes
// R1 - 40 levels: 8 regular, 32 bridge levels.
// R2 - Enhanced mode uses two pending, two mask registers.
// R3 - Enhanced enable bit selects mode; clear means regular.
// R4 - Reset leaves the regular controller running.
// R5 - Relocation gives each source its own vector.
// R6 - Relocation needs exception table relocation bit set.
// R7 - Dedicated relocation enable bit and table base register.
// R8 - Low priority masking masks same/lower levels in service.
// R9 - Software order: base, table, prefix, relocate, enable.
// R10 - Vector is base plus priority-ordered slot offset.
package eic_pkg;

   // Widths of the source groups
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned N_PIN     = 8;
   localparam int unsigned N_SYS     = 8;
   localparam int unsigned N_BRIDGE  = 32;
   localparam int unsigned N_REG     = 16;
   localparam int unsigned N_SRC     = 48;
   localparam int unsigned N_HI      = 16;
   localparam int unsigned IDX_W     = 6;
   localparam int unsigned N_EV      = 2;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_SYSIF_CFG  = 8'h00;
   localparam logic [7:0] OFS_BB_CFG     = 8'h04;
   localparam logic [7:0] OFS_RELOC_BASE = 8'h08;
   localparam logic [7:0] OFS_PEND_LEG   = 8'h0c;
   localparam logic [7:0] OFS_MASK_LEG   = 8'h10;
   localparam logic [7:0] OFS_PEND_A     = 8'h14;
   localparam logic [7:0] OFS_PEND_B     = 8'h18;
   localparam logic [7:0] OFS_MASK_A     = 8'h1c;
   localparam logic [7:0] OFS_MASK_B     = 8'h20;
   localparam logic [7:0] OFS_SVC_MASK_A = 8'h24;
   localparam logic [7:0] OFS_SVC_MASK_B = 8'h28;
   localparam logic [7:0] OFS_VEC_CODE   = 8'h2c;
   localparam logic [7:0] OFS_EV_STATUS  = 8'h30;
   localparam logic [7:0] OFS_EV_MASK    = 8'h34;
   localparam logic [7:0] OFS_INSVC_A    = 8'h38;
   localparam logic [7:0] OFS_INSVC_B    = 8'h3c;

   // Field positions
   localparam int unsigned SYSIF_ENH_BIT = 0;
   localparam int unsigned SYSIF_LPM_BIT = 1;
   localparam int unsigned BB_EXC_TABLE_RELOC_ENABLE_BIT   = 0;
   localparam int unsigned BB_RELOC_BIT  = 1;
   localparam int unsigned EV_ACK        = 0;
   localparam int unsigned EV_CFG_ERR    = 1;

   // Reset values and vector layout
   localparam logic [31:0] RELOC_BASE_RST = 32'h0000_0000;
   localparam logic [31:0] EXT_VECTOR_DEF = 32'h0000_0100;
   localparam int unsigned SLOT_SHIFT     = 2;

   typedef struct packed {
      logic lpm_en;
      logic enh_en;
   } eic_sysif_s;

   typedef struct packed {
      logic reloc_en;
      logic exc_table_reloc_enable;
   } eic_bbcfg_s;

   typedef enum logic [1:0] {
      EIC_IDLE   = 2'b00,
      EIC_REQ    = 2'b01,
      EIC_SETTLE = 2'b11
   } eic_state_e;

   // Sticky update where a set beats a clear in the same cycle
   function automatic logic [31:0] eic_sticky(input logic [31:0] cur,
                                              input logic [31:0] set,
                                              input logic [31:0] clr);
      return (cur & ~clr) | set;
   endfunction

endpackage

// *** hw/eic_rst_sync.sv ***
`timescale 1ns/1ps
module eic_rst_sync (
   input  wire logic sys_clk,    // System clock
   input  wire logic rst_n,      // Asynchronous reset, active low
   output logic      rst_sync_n  // Released copy, active low
);
   logic meta_n_r;

   // Two stages so the release never lands near an edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_n_r   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         meta_n_r   <= 1'b1;
         rst_sync_n <= meta_n_r;
      end
   end
endmodule // eic_rst_sync

// *** hw/eic_prio_enc.sv ***
`timescale 1ns/1ps
module eic_prio_enc
   import eic_pkg::*;
(
   input  wire logic [N_SRC-1:0] req,   // Request vector, bit 0 highest
   output logic                  valid, // Any bit set
   output logic [IDX_W-1:0]      idx    // Lowest set index
);
   // Scan downward so the lowest index wins
   always_comb begin
      valid = 1'b0;
      idx   = '0;
      for (int i = N_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            valid = 1'b1;
            idx   = IDX_W'(i);
         end
      end
   end
endmodule // eic_prio_enc

// *** hw/eic_top.sv ***
`timescale 1ns/1ps
module eic_top
   import eic_pkg::*;
#(
   parameter logic [31:0] EXT_VECTOR = EXT_VECTOR_DEF // Shared vector, value arbitrary
) (
   input  wire logic              sys_clk,      // 250 MHz system clock
   input  wire logic              rst_n,        // Asynchronous reset, active low
   input  wire logic [ADDR_W-1:0] reg_addr,     // Register byte address
   input  wire logic [DATA_W-1:0] reg_wdata,    // Write data
   input  wire logic              reg_wr,       // Write strobe
   input  wire logic              reg_rd,       // Read strobe
   output logic      [DATA_W-1:0] reg_rdata,    // Read data, cycle after strobe
   input  wire logic [N_PIN-1:0]  irq_pin,      // Interrupt pins, high = request
   input  wire logic [N_SYS-1:0]  sysif_level,  // System interface levels
   input  wire logic [N_BRIDGE-1:0] bridge_level, // Intermodule bridge levels
   input  wire logic              core_ack,     // Core takes the exception
   output logic                   core_irq,     // Request to the core
   output logic      [31:0]       core_vector,  // Exception vector address
   output logic      [IDX_W-1:0]  core_code,    // Code of the offered source
   output logic                   evt_irq       // Event interrupt, level
);

   logic rst_sync_n;

   eic_rst_sync u_rst (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .rst_sync_n (rst_sync_n)
   );

   // Configuration and mask registers
   eic_sysif_s          sysif_r,      sysif_nxt;
   eic_bbcfg_s          bbcfg_r,      bbcfg_nxt;
   logic [31:0]         base_r,       base_nxt;
   logic [N_REG-1:0]    mask_leg_r,   mask_leg_nxt;
   logic [31:0]         mask_a_r,     mask_a_nxt;
   logic [N_HI-1:0]     mask_b_r,     mask_b_nxt;
   logic [N_EV-1:0]     ev_stat_r,    ev_stat_nxt;
   logic [N_EV-1:0]     ev_mask_r,    ev_mask_nxt;
   logic [31:0]         insvc_a_r,    insvc_a_nxt;
   logic [N_HI-1:0]     insvc_b_r,    insvc_b_nxt;
   logic [N_SRC-1:0]    svc_mask_r,   svc_mask_nxt;
   logic [DATA_W-1:0]   rdata_r,      rdata_nxt;
   eic_state_e          state_r,      state_nxt;
   logic                irq_r,        irq_nxt;
   logic [31:0]         vec_r,        vec_nxt;
   logic [IDX_W-1:0]    code_r,       code_nxt;
   logic                evt_r,        evt_nxt;

   // Source gathering
   logic [N_REG-1:0]    reg_src;
   logic [N_SRC-1:0]    pend;
   logic [N_SRC-1:0]    mask_eff;
   logic [N_SRC-1:0]    eligible;
   logic [N_SRC-1:0]    insvc;
   logic                win_valid;
   logic [IDX_W-1:0]    win_idx;
   logic                svc_valid;
   logic [IDX_W-1:0]    svc_idx;
   logic                reloc_active;
   logic                cfg_err;
   logic [N_SRC-1:0]    ack_set;
   logic                wr_ev_stat;
   logic                wr_insvc_a;
   logic                wr_insvc_b;

   // Pins and levels interleave, pin k just above level k
   always_comb begin
      reg_src = '0;
      for (int k = 0; k < N_SYS; k++) begin
         reg_src[2*k]   = irq_pin[k];
         reg_src[2*k+1] = sysif_level[k];
         if (!sysif_r.enh_en) begin // R3
            // Regular mode folds the bridge onto the 8 levels
            for (int j = k; j < N_BRIDGE; j += N_SYS) begin
               reg_src[2*k+1] = reg_src[2*k+1] | bridge_level[j]; // R1
            end
         end
      end
   end

   // Enhanced mode adds the 32 bridge levels below the regular set
   assign pend = sysif_r.enh_en ? {bridge_level, reg_src} // R1
                                : {{N_BRIDGE{1'b0}}, reg_src};

   // Mask source follows the mode
   assign mask_eff = sysif_r.enh_en ? {mask_b_r, mask_a_r} // R2
                                    : {{N_BRIDGE{1'b0}}, mask_leg_r};

   // In-service tracking only matters with automatic masking
   assign insvc    = {insvc_b_r, insvc_a_r};
   assign eligible = pend & mask_eff & ~svc_mask_r;

   eic_prio_enc u_win (
      .req   (eligible),
      .valid (win_valid),
      .idx   (win_idx)
   );

   // Highest source in service sets the masking floor
   eic_prio_enc u_svc (
      .req   (insvc),
      .valid (svc_valid),
      .idx   (svc_idx)
   );

   // Relocation needs its own bit, the table bit and enhanced mode
   assign reloc_active = sysif_r.enh_en & bbcfg_r.reloc_en & bbcfg_r.exc_table_reloc_enable; // R6 R7
   assign cfg_err      = sysif_r.enh_en & bbcfg_r.reloc_en & ~bbcfg_r.exc_table_reloc_enable; // R6

   // Service mask covers the floor and everything below it
   always_comb begin
      svc_mask_nxt = '0;
      for (int i = 0; i < N_SRC; i++) begin
         if (sysif_r.enh_en && sysif_r.lpm_en && svc_valid &&
             (IDX_W'(i) >= svc_idx)) begin
            svc_mask_nxt[i] = 1'b1; // R8
         end
      end
   end

   // Request state machine towards the core
   always_comb begin
      state_nxt = state_r;
      irq_nxt   = irq_r;
      vec_nxt   = vec_r;
      code_nxt  = code_r;
      ack_set   = '0;
      case (state_r)
         EIC_IDLE: begin
            if (win_valid) begin
               state_nxt = EIC_REQ;
               irq_nxt   = 1'b1;
            end
         end
         EIC_REQ: begin
            if (core_ack) begin
               // Hold off one cycle so the new service mask settles
               state_nxt = EIC_SETTLE;
               irq_nxt   = 1'b0;
               if (sysif_r.enh_en && sysif_r.lpm_en) begin
                  ack_set[code_r] = 1'b1; // R8
               end
            end else if (!win_valid) begin
               state_nxt = EIC_IDLE;
               irq_nxt   = 1'b0;
            end
         end
         EIC_SETTLE: begin
            state_nxt = EIC_IDLE;
         end
         default: begin
            state_nxt = EIC_IDLE;
            irq_nxt   = 1'b0;
         end
      endcase
      // Vector tracks the winner until the core takes it
      if (state_nxt == EIC_REQ && win_valid && !core_ack) begin
         code_nxt = win_idx;
         if (reloc_active) begin
            vec_nxt = base_r + (32'(win_idx) << SLOT_SHIFT); // R5 R10
         end else begin
            vec_nxt = EXT_VECTOR;
         end
      end
   end

   // Write side decode of the one-to-clear registers
   assign wr_ev_stat = reg_wr && (reg_addr == OFS_EV_STATUS);
   assign wr_insvc_a = reg_wr && (reg_addr == OFS_INSVC_A);
   assign wr_insvc_b = reg_wr && (reg_addr == OFS_INSVC_B);

   // Register writes and sticky updates
   always_comb begin
      logic [31:0] ev_tmp;
      logic [31:0] insb_tmp;
      ev_tmp       = '0;
      insb_tmp     = '0;
      sysif_nxt    = sysif_r;
      bbcfg_nxt    = bbcfg_r;
      base_nxt     = base_r;
      mask_leg_nxt = mask_leg_r;
      mask_a_nxt   = mask_a_r;
      mask_b_nxt   = mask_b_r;
      ev_mask_nxt  = ev_mask_r;
      if (reg_wr) begin
         case (reg_addr)
            OFS_SYSIF_CFG: begin
               sysif_nxt.enh_en = reg_wdata[SYSIF_ENH_BIT]; // R3
               sysif_nxt.lpm_en = reg_wdata[SYSIF_LPM_BIT]; // R8
            end
            OFS_BB_CFG: begin
               bbcfg_nxt.exc_table_reloc_enable     = reg_wdata[BB_EXC_TABLE_RELOC_ENABLE_BIT];  // R6
               bbcfg_nxt.reloc_en = reg_wdata[BB_RELOC_BIT]; // R7
            end
            OFS_RELOC_BASE: base_nxt     = reg_wdata; // R7
            OFS_MASK_LEG:   mask_leg_nxt = reg_wdata[N_REG-1:0];
            OFS_MASK_A:     mask_a_nxt   = reg_wdata; // R2
            OFS_MASK_B:     mask_b_nxt   = reg_wdata[N_HI-1:0]; // R2
            OFS_EV_MASK:    ev_mask_nxt  = reg_wdata[N_EV-1:0];
            default: begin
            end
         endcase
      end
      // Events win over a clear landing in the same cycle
      ev_tmp      = eic_sticky({30'h0, ev_stat_r},
                               {30'h0, cfg_err, ack_set != '0},
                               wr_ev_stat ? reg_wdata : 32'h0);
      ev_stat_nxt = ev_tmp[N_EV-1:0];
      // Service end is a one-to-clear of the in-service bit
      insvc_a_nxt = eic_sticky(insvc_a_r, ack_set[31:0],
                               wr_insvc_a ? reg_wdata : 32'h0); // R8
      insb_tmp    = eic_sticky({16'h0, insvc_b_r}, {16'h0, ack_set[N_SRC-1:32]},
                               wr_insvc_b ? reg_wdata : 32'h0);
      insvc_b_nxt = insb_tmp[N_HI-1:0];
      // Leaving enhanced masking drops any stale service state
      if (!(sysif_r.enh_en && sysif_r.lpm_en)) begin
         insvc_a_nxt = '0;
         insvc_b_nxt = '0;
      end
      evt_nxt = |(ev_stat_nxt & ev_mask_nxt);
   end

   // Read mux, data valid in the cycle after the strobe
   always_comb begin
      rdata_nxt = '0;
      if (reg_rd) begin
         case (reg_addr)
            OFS_SYSIF_CFG: begin
               rdata_nxt[SYSIF_ENH_BIT] = sysif_r.enh_en;
               rdata_nxt[SYSIF_LPM_BIT] = sysif_r.lpm_en;
            end
            OFS_BB_CFG: begin
               rdata_nxt[BB_EXC_TABLE_RELOC_ENABLE_BIT]  = bbcfg_r.exc_table_reloc_enable;
               rdata_nxt[BB_RELOC_BIT] = bbcfg_r.reloc_en;
            end
            OFS_RELOC_BASE: rdata_nxt = base_r;
            // Legacy pending reads zero in enhanced mode
            OFS_PEND_LEG:   rdata_nxt = sysif_r.enh_en ? 32'h0 : {16'h0, reg_src}; // R2
            OFS_MASK_LEG:   rdata_nxt = {16'h0, mask_leg_r};
            OFS_PEND_A:     rdata_nxt = sysif_r.enh_en ? pend[31:0] : 32'h0; // R2
            OFS_PEND_B:     rdata_nxt = sysif_r.enh_en ? {16'h0, pend[N_SRC-1:32]} : 32'h0;
            OFS_MASK_A:     rdata_nxt = mask_a_r;
            OFS_MASK_B:     rdata_nxt = {16'h0, mask_b_r};
            OFS_SVC_MASK_A: rdata_nxt = svc_mask_r[31:0]; // R8
            OFS_SVC_MASK_B: rdata_nxt = {16'h0, svc_mask_r[N_SRC-1:32]};
            OFS_VEC_CODE:   rdata_nxt = {26'h0, code_r};
            OFS_EV_STATUS:  rdata_nxt = {30'h0, ev_stat_r};
            OFS_EV_MASK:    rdata_nxt = {30'h0, ev_mask_r};
            OFS_INSVC_A:    rdata_nxt = insvc_a_r;
            OFS_INSVC_B:    rdata_nxt = {16'h0, insvc_b_r};
            default:        rdata_nxt = '0;
         endcase
      end
   end

   // All state registers; reset leaves the regular controller active
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sysif_r    <= '0; // R4
         bbcfg_r    <= '0;
         base_r     <= RELOC_BASE_RST;
         mask_leg_r <= '0;
         mask_a_r   <= '0;
         mask_b_r   <= '0;
         ev_stat_r  <= '0;
         ev_mask_r  <= '0;
         insvc_a_r  <= '0;
         insvc_b_r  <= '0;
         svc_mask_r <= '0;
         rdata_r    <= '0;
         state_r    <= EIC_IDLE;
         irq_r      <= 1'b0;
         vec_r      <= '0;
         code_r     <= '0;
         evt_r      <= 1'b0;
      end else begin
         sysif_r    <= sysif_nxt;
         bbcfg_r    <= bbcfg_nxt;
         base_r     <= base_nxt;
         mask_leg_r <= mask_leg_nxt;
         mask_a_r   <= mask_a_nxt;
         mask_b_r   <= mask_b_nxt;
         ev_stat_r  <= ev_stat_nxt;
         ev_mask_r  <= ev_mask_nxt;
         insvc_a_r  <= insvc_a_nxt;
         insvc_b_r  <= insvc_b_nxt;
         svc_mask_r <= svc_mask_nxt;
         rdata_r    <= rdata_nxt;
         state_r    <= state_nxt;
         irq_r      <= irq_nxt;
         vec_r      <= vec_nxt;
         code_r     <= code_nxt;
         evt_r      <= evt_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata   = rdata_r;
   assign core_irq    = irq_r;
   assign core_vector = vec_r;
   assign core_code   = code_r;
   assign evt_irq     = evt_r;

endmodule // eic_top

// *** test/eic_chk_sva.sv ***
`timescale 1ns/1ps
module eic_chk
   import eic_pkg::*;
#(
   parameter logic [31:0] EXT_VECTOR = EXT_VECTOR_DEF // Shared vector
) (
   input wire logic                sys_clk,      // Clock
   input wire logic                rst_n,        // Reset, active low
   input wire logic [ADDR_W-1:0]   reg_addr,     // Address
   input wire logic [DATA_W-1:0]   reg_wdata,    // Write data
   input wire logic                reg_wr,       // Write strobe
   input wire logic                reg_rd,       // Read strobe
   input wire logic [DATA_W-1:0]   reg_rdata,    // Read data
   input wire logic [N_PIN-1:0]    irq_pin,      // Pins
   input wire logic [N_SYS-1:0]    sysif_level,  // Levels
   input wire logic [N_BRIDGE-1:0] bridge_level, // Bridge levels
   input wire logic                core_ack,     // Core take
   input wire logic                core_irq,     // Request
   input wire logic [31:0]         core_vector,  // Vector
   input wire logic [IDX_W-1:0]    core_code,    // Code
   input wire logic                evt_irq       // Event
);
   eic_sysif_s  sif_r, sif_nxt;
   eic_bbcfg_s  bb_r, bb_nxt;
   logic [31:0] base_r, base_nxt;
   logic [1:0]  quiet_r, quiet_nxt;
   logic        reloc;
   logic        src_any;

   // Shadow config; vector lags a write, so judge it only once quiet
   always_comb begin
      sif_nxt = sif_r;
      bb_nxt = bb_r;
      base_nxt = base_r;
      quiet_nxt = (quiet_r == 2'h3) ? quiet_r : quiet_r + 2'h1;
      if (reg_wr) begin
         quiet_nxt = 2'h0;
         if (reg_addr == OFS_SYSIF_CFG) sif_nxt = eic_sysif_s'(reg_wdata[1:0]);
         if (reg_addr == OFS_BB_CFG) bb_nxt = eic_bbcfg_s'(reg_wdata[1:0]);
         if (reg_addr == OFS_RELOC_BASE) base_nxt = reg_wdata;
      end
   end

   // Shadow registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sif_r <= '0;
         bb_r <= '0;
         base_r <= RELOC_BASE_RST;
         quiet_r <= 2'h0;
      end else begin
         sif_r <= sif_nxt;
         bb_r <= bb_nxt;
         base_r <= base_nxt;
         quiet_r <= quiet_nxt;
      end
   end

   // Relocation and source summary
   assign reloc = sif_r.enh_en & bb_r.reloc_en & bb_r.exc_table_reloc_enable;
   assign src_any = |{irq_pin, sysif_level, bridge_level};

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   ack_drop_a: assert property (core_irq && core_ack |=> !core_irq [*2])
      else $error("request not withdrawn after take");
   vec_form_a: assert property (core_irq && quiet_r == 2'h3 |-> core_vector ==
      (reloc ? base_r + (32'(core_code) << SLOT_SHIFT) : EXT_VECTOR))
      else $error("vector not formed from base and code");
   rd_idle_a: assert property ($past(!reg_rd || reg_addr > OFS_INSVC_B) |-> reg_rdata == '0)
      else $error("read data outside a valid read");
   pend_reg_a: assert property ($past(reg_rd && reg_addr == OFS_PEND_A && !sif_r.enh_en)
      |-> reg_rdata == '0) else $error("wide pending seen in regular mode");
   leg_enh_a: assert property ($past(reg_rd && reg_addr == OFS_PEND_LEG && sif_r.enh_en)
      |-> reg_rdata == '0) else $error("legacy pending seen in enhanced mode");
   code_reg_a: assert property (core_irq && !sif_r.enh_en && quiet_r == 2'h3
      |-> core_code < 6'h10) else $error("bridge index offered in regular mode");
   irq_cause_a: assert property ($rose(core_irq) |-> $past(src_any))
      else $error("request without any source");
   rst_quiet_a: assert property (disable iff (1'b0) !rst_n |-> !core_irq && !evt_irq)
      else $error("outputs active in reset");

   cover property (core_irq && core_ack && reloc);
   cover property (core_irq && core_ack && sif_r.lpm_en);
   cover property ($rose(evt_irq));
endmodule // eic_chk

bind eic_top eic_chk #(.EXT_VECTOR(EXT_VECTOR)) u_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_pin(irq_pin),
   .sysif_level(sysif_level), .bridge_level(bridge_level), .core_ack(core_ack),
   .core_irq(core_irq), .core_vector(core_vector), .core_code(core_code), .evt_irq(evt_irq));

// *** test/eic_core_model.sv ***
`timescale 1ns/1ps
module eic_core_model
   import eic_pkg::*;
(
   input  wire logic             sys_clk,     // Clock
   input  wire logic             rst_n,       // Reset, active low
   input  wire logic             core_irq,    // Offered request
   input  wire logic [31:0]      core_vector, // Offered vector
   input  wire logic [IDX_W-1:0] core_code,   // Offered code
   input  wire logic [3:0]       lat,         // Cycles before taking
   output logic                  core_ack,    // Take pulse
   output logic [31:0]           got_vec,     // Vector taken
   output logic [IDX_W-1:0]      got_code,    // Code taken
   output logic [7:0]            taken        // Count of takes
);
   logic [3:0] cnt_r;

   // One-cycle take; a request that vanishes restarts the wait
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_ack <= 1'b0;
         cnt_r <= 4'h0;
         got_vec <= 32'h0;
         got_code <= '0;
         taken <= 8'h0;
      end else begin
         core_ack <= 1'b0;
         cnt_r <= 4'h0;
         // Take what is shown at the edge the design sees the take
         if (core_irq && core_ack) begin
            got_vec <= core_vector;
            got_code <= core_code;
            taken <= taken + 8'h1;
         end
         if (core_irq && !core_ack) begin
            if (cnt_r == lat) begin
               core_ack <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 4'h1;
            end
         end
      end
   end
endmodule // eic_core_model

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb
   import eic_pkg::*;
;
   localparam logic [31:0] XV = 32'h0000_0300; // Arbitrary shared vector
   logic                sys_clk, rst_n, reg_wr, reg_rd, core_ack, core_irq, evt_irq;
   logic [ADDR_W-1:0]   reg_addr;
   logic [DATA_W-1:0]   reg_wdata, reg_rdata;
   logic [N_PIN-1:0]    irq_pin;
   logic [N_SYS-1:0]    sysif_level;
   logic [N_BRIDGE-1:0] bridge_level;
   logic [31:0]         core_vector, got_vec;
   logic [IDX_W-1:0]    core_code, got_code;
   logic [7:0]          taken;
   logic [3:0]          lat;
   int                  errors, checks;

   eic_top #(.EXT_VECTOR(XV)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq_pin(irq_pin), .sysif_level(sysif_level),
      .bridge_level(bridge_level), .core_ack(core_ack), .core_irq(core_irq),
      .core_vector(core_vector), .core_code(core_code), .evt_irq(evt_irq));
   eic_core_model u_core (.sys_clk(sys_clk), .rst_n(rst_n), .core_irq(core_irq),
      .core_vector(core_vector), .core_code(core_code), .lat(lat), .core_ack(core_ack),
      .got_vec(got_vec), .got_code(got_code), .taken(taken));

   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask

   // Bus cycles leave one idle cycle so a strobe is never set twice at once
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffff_ffff);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check(nm, reg_rdata & m, e);
      @(posedge sys_clk);
   endtask

   // Wait for the core to take a request, then judge code and vector
   task automatic take(input logic [IDX_W-1:0] c, input logic [31:0] v, input logic [7:0] n);
      int i;
      i = 0;
      while (taken == n && i < 50) begin
         @(posedge sys_clk);
         i++;
      end
      #1;
      check("code", {26'h0, got_code}, {26'h0, c});
      check("vector", got_vec, v);
      check("taken", {24'h0, taken}, {24'h0, n} + 32'h1);
      @(posedge sys_clk);
   endtask

   task automatic t_regular();
      logic [7:0] n;
      rd("sysif", OFS_SYSIF_CFG, 32'h0);
      rd("bbcfg", OFS_BB_CFG, 32'h0);
      wr(OFS_MASK_LEG, 32'h0000_ffff);
      n = taken;
      bridge_level <= 32'h0000_0400; // Folds onto level 2, index 5
      take(6'h05, XV, n);
      rd("pend_leg", OFS_PEND_LEG, 32'h0000_0020);
      rd("pend_a", OFS_PEND_A, 32'h0);
      rd("hole", 8'h40, 32'h0);
      bridge_level <= 32'h0;
      // Let a take still in flight for the bridge level finish first
      repeat (4) @(posedge sys_clk);
      n = taken;
      sysif_level <= 8'h08; // Level 3, index 7
      take(6'h07, XV, n);
      sysif_level <= 8'h00;
   endtask

   task automatic t_enhanced();
      logic [7:0] n;
      wr(OFS_SYSIF_CFG, 32'h1);
      wr(OFS_MASK_A, 32'hffff_ffff);
      wr(OFS_MASK_B, 32'h0);
      bridge_level <= 32'h8000_0000; // Index 47, the lowest level
      repeat (6) @(posedge sys_clk);
      #1 check("masked", {31'h0, core_irq}, 32'h0);
      @(posedge sys_clk);
      rd("pend_b", OFS_PEND_B, 32'h0000_8000);
      rd("pend_leg", OFS_PEND_LEG, 32'h0);
      n = taken;
      wr(OFS_MASK_B, 32'h0000_ffff);
      take(6'h2f, XV, n);
      bridge_level <= 32'h0;
   endtask

   task automatic t_reloc();
      logic [7:0] n;
      wr(OFS_SYSIF_CFG, 32'h0);
      wr(OFS_RELOC_BASE, 32'h0000_2000);
      wr(OFS_BB_CFG, 32'h2);
      wr(OFS_SYSIF_CFG, 32'h1);
      wr(OFS_EV_STATUS, 32'h3);
      rd("cfg_err", OFS_EV_STATUS, 32'h2, 32'h2);
      #1 check("evt_off", {31'h0, evt_irq}, 32'h0);
      @(posedge sys_clk);
      wr(OFS_EV_MASK, 32'h2);
      #1 check("evt_on", {31'h0, evt_irq}, 32'h1);
      @(posedge sys_clk);
      n = taken;
      irq_pin <= 8'h08; // Pin 3, index 6
      take(6'h06, XV, n);
      irq_pin <= 8'h00;
      wr(OFS_BB_CFG, 32'h3);
      wr(OFS_EV_STATUS, 32'h3);
      #1 check("evt_clr", {31'h0, evt_irq}, 32'h0);
      @(posedge sys_clk);
      n = taken;
      irq_pin <= 8'h08;
      take(6'h06, 32'h0000_2018, n);
      irq_pin <= 8'h00;
   endtask

   // Slow core; the held source must not return while in service
   task automatic t_nest();
      logic [7:0] n;
      wr(OFS_SYSIF_CFG, 32'h3);
      lat <= 4'h3;
      n = taken;
      irq_pin <= 8'h20; // Pin 5, index 10
      take(6'h0a, 32'h0000_2028, n);
      repeat (4) @(posedge sys_clk);
      #1 check("held", {31'h0, core_irq}, 32'h0);
      @(posedge sys_clk);
      rd("svc_a", OFS_SVC_MASK_A, 32'hffff_fc00);
      rd("svc_b", OFS_SVC_MASK_B, 32'h0000_ffff);
      n = taken;
      irq_pin <= 8'h22; // Pin 1, index 2 nests above
      take(6'h02, 32'h0000_2008, n);
      irq_pin <= 8'h00;
      rd("vec_code", OFS_VEC_CODE, 32'h0000_0002);
      rd("insvc_a", OFS_INSVC_A, 32'h0000_0404);
      wr(OFS_INSVC_A, 32'h0000_0404);
      rd("svc_end", OFS_SVC_MASK_A, 32'h0);
   endtask

   task automatic finish_test();
      if (errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      irq_pin = '0;
      sysif_level = '0;
      bridge_level = '0;
      lat = 4'h0;
      #1 rst_n = 1'b0; // Falls once every process waits on it
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      sysif_level <= 8'h00;
      t_regular();
      t_enhanced();
      t_reloc();
      t_nest();
      finish_test();
   end

   // The run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      errors++;
      finish_test();
   end
endmodule // tb
